// ### rtl/serial_port_pkg.sv
// Package of register map, field layout and constants for the pin/rate block
package serial_port_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PIN_CTRL = 8'h01;
   localparam logic [7:0] IDX_RATE_DIV = 8'h02;
   localparam logic [7:0] IDX_PORT_MODE = 8'h04;
   localparam logic [7:0] IDX_PORT_STAT = 8'h05;
   localparam int ADDR_SHIFT = 2;

   // serial_pin_ctrl fields
   localparam int PC_MODE_FAULT_EN = 4;
   localparam int PC_BIDIR_OE = 3;
   localparam int PC_HALT_IN_WAIT = 1;
   localparam int PC_SINGLE_WIRE = 0;
   localparam logic [7:0] PC_WR_MASK = 8'h1b;
   localparam logic [7:0] PC_RESET = 8'h00;

   // serial_rate_div fields
   localparam int RD_PRESCALE_LSB = 4;
   localparam int RD_SHIFT_LSB = 0;
   localparam int RATE_FIELD_W = 3;
   localparam logic [7:0] RD_WR_MASK = 8'h77;
   localparam logic [7:0] RD_RESET = 8'h00;

   // port_mode fields
   localparam int PM_MASTER_SELECT = 0;
   localparam int PM_SELECT_OUT_EN = 1;
   localparam logic [7:0] PM_WR_MASK = 8'h03;
   localparam logic [7:0] PM_RESET = 8'h00;

   // port_stat fields; a write of one to the fault bit clears it
   localparam int PS_MODE_FAULT = 0;
   localparam int PS_SCLK_RUN = 1;
   localparam int PS_SS_LEVEL = 2;
   localparam int PS_XFER_BUSY = 3;

   // Half period counter width: largest half divisor is 8 * 2^7 = 1024
   localparam int HALF_CNT_W = 11;

   typedef enum logic [1:0] {
      SS_UNUSED,
      SS_FAULT_INPUT,
      SS_SELECT_OUTPUT,
      SS_SLAVE_INPUT
   } ss_use_t;
endpackage

// ### rtl/serial_rate_gen.sv
// Serial clock rate divider producing half-period enable pulses
`timescale 1ns/1ps
module serial_rate_gen
   import serial_port_pkg::*;
#(
   parameter int FIELD_W = RATE_FIELD_W,
   parameter int CNT_W = HALF_CNT_W
) (
   input wire logic clk, // Bus clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic clear, // Restart count from zero
   input wire logic run, // Count enable
   input wire logic [FIELD_W-1:0] prescale, // Prescale field
   input wire logic [FIELD_W-1:0] shift, // Power-of-two field
   output logic halfTick // One pulse per half serial period
);
   initial begin
      if (FIELD_W != 3 || CNT_W < 11) begin
         $error("serial_rate_gen: unsupported field or counter width");
      end
   end

   logic [CNT_W-1:0] count;
   logic [CNT_W-1:0] halfDiv;
   logic [CNT_W-1:0] prescalePlusOne;
   logic atEnd;

   // Divisor is (p+1)*2^(s+1); one half period is (p+1)*2^s
   assign prescalePlusOne = CNT_W'(prescale) + CNT_W'(1);
   assign halfDiv = prescalePlusOne << shift;
   assign atEnd = (count == halfDiv - CNT_W'(1));

   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count <= '0;
         halfTick <= 1'b0;
      end else if (run) begin
         count <= atEnd ? '0 : count + CNT_W'(1);
         halfTick <= atEnd;
      end else begin
         halfTick <= 1'b0;
      end
   end
endmodule

// ### rtl/serial_pin_rate_ctrl.sv
// Pin configuration, slave select use and serial clock rate control
//
// Summary of operation
// - Master, fault detect off: select pin unused
// - Master, fault on, output off: monitored input
// - Master, fault and output on: drive select
// - Slave: select pin always an input
// - Master: fault/pin/rate change aborts to idle
// - Master single-wire: output-enable change aborts
// - Single-wire output enable gates data buffer
// - Pin mode zero: normal two-wire data pins
// - Master single-wire: only the master-out pin
// - Slave single-wire: only the master-in pin
// - Halt bit stops serial clock in wait
// - Prescale field in rate bits 6 to 4
// - Shift field in rate bits 2 to 0
// - Divisor is (prescale+1) times 2^(shift+1)
// - Serial clock equals bus clock over divisor
// - Both registers read/write anytime, reserved ignored
// - Select low in master with detect on and output off sets fault
// - Master select bit; role switch goes idle
// - Select output needs master and fault detect
`timescale 1ns/1ps
module serial_pin_rate_ctrl
   import serial_port_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk, // Bus clock, 200 MHz
   input wire logic rst, // Synchronous reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [ADDR_W-1:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic waitMode, // System wait mode
   input wire logic xferBusy, // Shift engine is moving a byte
   input wire logic txBit, // Bit to send from shift engine
   output logic rxBit, // Bit received from the active data pin
   output logic sclk, // Serial clock level, master only
   output logic sclkTick, // Pulse on each serial clock edge
   output logic masterMode, // Role for the shift engine
   output logic abortToIdle, // Pulse: force shift engine idle
   output logic modeFault, // Sticky mode fault flag
   input wire logic ssIn, // Slave select pin input
   output logic ssOut, // Slave select pin output
   output logic select_output_en, // Slave select pin output enable
   input wire logic mosiIn, // Master-out pin input
   output logic mosiOut, // Master-out pin output
   output logic mosiOe, // Master-out pin output enable
   input wire logic misoIn, // Master-in pin input
   output logic misoOut, // Master-in pin output
   output logic misoOe // Master-in pin output enable
);
   initial begin
      if (ADDR_W < 5) begin
         $error("serial_pin_rate_ctrl: address too narrow for the map");
      end
   end

   // ---------------- Registers ----------------
   logic [7:0] pinCtrl;
   logic [7:0] rateDiv;
   logic [7:0] portMode;
   logic [7:0] prevPinCtrl;
   logic [7:0] prevRateDiv;
   logic [7:0] prevPortMode;

   // ---------------- APB decode ----------------
   wire accessPhase = psel && penable;
   wire xferDone = accessPhase && pready;
   wire wrDone = xferDone && pwrite;
   wire [ADDR_W-1:0] wordIdx = paddr >> ADDR_SHIFT;
   // Unaligned accesses fall outside the map and get an error response
   wire aligned = (paddr[1:0] == 2'b00);
   wire hitPinCtrl = aligned && (wordIdx == ADDR_W'(IDX_PIN_CTRL));
   wire hitRateDiv = aligned && (wordIdx == ADDR_W'(IDX_RATE_DIV));
   wire hitPortMode = aligned && (wordIdx == ADDR_W'(IDX_PORT_MODE));
   wire hitPortStat = aligned && (wordIdx == ADDR_W'(IDX_PORT_STAT));
   wire mapped = hitPinCtrl || hitRateDiv || hitPortMode || hitPortStat;
   wire [7:0] wrByte = pwdata[7:0];

   // ---------------- Field views ----------------
   wire master = portMode[PM_MASTER_SELECT];
   wire selectOutEn = portMode[PM_SELECT_OUT_EN];
   wire faultDetectEn = pinCtrl[PC_MODE_FAULT_EN];
   wire bidir_output_en = pinCtrl[PC_BIDIR_OE];
   wire haltInWait = pinCtrl[PC_HALT_IN_WAIT];
   wire singleWire = pinCtrl[PC_SINGLE_WIRE];
   wire [RATE_FIELD_W-1:0] prescaleField =
      rateDiv[RD_PRESCALE_LSB +: RATE_FIELD_W];
   wire [RATE_FIELD_W-1:0] shiftField =
      rateDiv[RD_SHIFT_LSB +: RATE_FIELD_W];

   // ---------------- Select pin use ----------------
   ss_use_t ssUse;
   always_comb begin
      if (!master) begin
         ssUse = SS_SLAVE_INPUT;
      end else if (!faultDetectEn) begin
         ssUse = SS_UNUSED;
      end else if (!selectOutEn) begin
         ssUse = SS_FAULT_INPUT;
      end else begin
         ssUse = SS_SELECT_OUTPUT;
      end
   end

   // ---------------- Abort detection ----------------
   // Compare against last cycle's copy so any source of change is seen,
   // not only the bus write that caused it.
   wire pinCfgChanged =
      (pinCtrl[PC_MODE_FAULT_EN] != prevPinCtrl[PC_MODE_FAULT_EN]) ||
      (pinCtrl[PC_SINGLE_WIRE] != prevPinCtrl[PC_SINGLE_WIRE]);
   wire rateChanged = (rateDiv != prevRateDiv);
   wire bidirChanged = (pinCtrl[PC_BIDIR_OE] != prevPinCtrl[PC_BIDIR_OE])
      && (singleWire || prevPinCtrl[PC_SINGLE_WIRE]);
   wire selOutChanged =
      portMode[PM_SELECT_OUT_EN] != prevPortMode[PM_SELECT_OUT_EN];
   wire roleChanged =
      portMode[PM_MASTER_SELECT] != prevPortMode[PM_MASTER_SELECT];
   wire wasMaster = prevPortMode[PM_MASTER_SELECT];
   wire masterCfgAbort = (master || wasMaster) &&
      (pinCfgChanged || rateChanged || selOutChanged);
   wire bidirAbort = (master || wasMaster) && bidirChanged;
   wire next_abort = masterCfgAbort || bidirAbort || roleChanged;

   // ---------------- Mode fault ----------------
   // Level detect: a select held low keeps the flag set even across a
   // software clear, so the fault cannot be missed.
   wire faultSet = (ssUse == SS_FAULT_INPUT) && !ssIn;
   wire faultClr = wrDone && hitPortStat && wrByte[PS_MODE_FAULT];
   wire next_modeFault = faultSet || (modeFault && !faultClr);

   // ---------------- Serial clock ----------------
   wire clockHalted = haltInWait && waitMode;
   wire sclkRun = master && xferBusy && !clockHalted && !abortToIdle;
   wire sclkClear = !xferBusy || !master || abortToIdle;
   logic halfTick;

   serial_rate_gen #(
      .FIELD_W(RATE_FIELD_W),
      .CNT_W(HALF_CNT_W)
   ) rateGen (
      .clk(clk),
      .rst(rst),
      .clear(sclkClear),
      .run(sclkRun),
      .prescale(prescaleField),
      .shift(shiftField),
      .halfTick(halfTick)
   );

   // ---------------- Data pin routing ----------------
   logic next_mosiOe;
   logic next_mosiOut;
   logic next_misoOe;
   logic next_misoOut;
   logic next_rxBit;
   always_comb begin
      next_mosiOe = 1'b0;
      next_mosiOut = 1'b0;
      next_misoOe = 1'b0;
      next_misoOut = 1'b0;
      next_rxBit = 1'b0;
      if (master && !singleWire) begin
         next_mosiOe = 1'b1;
         next_mosiOut = txBit;
         next_rxBit = misoIn;
      end else if (master) begin
         next_mosiOe = bidir_output_en;
         next_mosiOut = txBit;
         next_rxBit = mosiIn;
      end else if (!singleWire) begin
         next_misoOe = 1'b1;
         next_misoOut = txBit;
         next_rxBit = mosiIn;
      end else begin
         next_misoOe = bidir_output_en;
         next_misoOut = txBit;
         next_rxBit = misoIn;
      end
   end

   // ---------------- Select pin drive ----------------
   wire next_select_output_en = (ssUse == SS_SELECT_OUTPUT);
   wire next_ssOut = !(next_select_output_en && xferBusy && !abortToIdle);

   // ---------------- Read data ----------------
   // Status bits placed by name so the layout follows the package
   logic [7:0] statByte;
   always_comb begin
      statByte = 8'h00;
      statByte[PS_MODE_FAULT] = modeFault;
      statByte[PS_SCLK_RUN] = sclkRun;
      statByte[PS_SS_LEVEL] = ssIn;
      statByte[PS_XFER_BUSY] = xferBusy;
   end
   logic [7:0] rdByte;
   always_comb begin
      rdByte = 8'h00;
      if (hitPinCtrl) begin
         rdByte = pinCtrl & PC_WR_MASK;
      end else if (hitRateDiv) begin
         rdByte = rateDiv & RD_WR_MASK;
      end else if (hitPortMode) begin
         rdByte = portMode & PM_WR_MASK;
      end else if (hitPortStat) begin
         rdByte = statByte;
      end
   end

   // ---------------- APB slave: one wait state ----------------
   always_ff @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= accessPhase && !pready;
         pslverr <= accessPhase && !pready && !mapped;
         prdata <= (accessPhase && !pready && !pwrite) ?
            {24'h0, rdByte} : 32'h0;
      end
   end

   // ---------------- Register writes ----------------
   wire wrPinCtrl = wrDone && hitPinCtrl;
   wire wrRateDiv = wrDone && hitRateDiv;
   wire wrPortMode = wrDone && hitPortMode;

   always_ff @(posedge clk) begin
      if (rst) begin
         pinCtrl <= PC_RESET;
      end else if (wrPinCtrl) begin
         pinCtrl <= wrByte & PC_WR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rateDiv <= RD_RESET;
      end else if (wrRateDiv) begin
         rateDiv <= wrByte & RD_WR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         portMode <= PM_RESET;
      end else if (wrPortMode) begin
         portMode <= wrByte & PM_WR_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prevPinCtrl <= PC_RESET;
         prevRateDiv <= RD_RESET;
         prevPortMode <= PM_RESET;
      end else begin
         prevPinCtrl <= pinCtrl;
         prevRateDiv <= rateDiv;
         prevPortMode <= portMode;
      end
   end

   // ---------------- Control and fault state ----------------
   always_ff @(posedge clk) begin
      if (rst) begin
         abortToIdle <= 1'b0;
      end else begin
         abortToIdle <= next_abort;
      end
   end

   // Set outranks a software clear landing in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         modeFault <= 1'b0;
      end else begin
         modeFault <= next_modeFault;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         masterMode <= 1'b0;
      end else begin
         masterMode <= master;
      end
   end

   // ---------------- Serial clock output ----------------
   // Idle level is low; the edge pulse lines up with the level change
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk <= 1'b0;
         sclkTick <= 1'b0;
      end else if (sclkClear) begin
         sclk <= 1'b0;
         sclkTick <= 1'b0;
      end else begin
         sclk <= halfTick ? !sclk : sclk;
         sclkTick <= halfTick;
      end
   end

   // ---------------- Pin outputs ----------------
   always_ff @(posedge clk) begin
      if (rst) begin
         mosiOe <= 1'b0;
         mosiOut <= 1'b0;
         misoOe <= 1'b0;
         misoOut <= 1'b0;
      end else begin
         mosiOe <= next_mosiOe;
         mosiOut <= next_mosiOut;
         misoOe <= next_misoOe;
         misoOut <= next_misoOut;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rxBit <= 1'b0;
      end else begin
         rxBit <= next_rxBit;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         select_output_en <= 1'b0;
         ssOut <= 1'b1;
      end else begin
         select_output_en <= next_select_output_en;
         ssOut <= next_ssOut;
      end
   end
endmodule

// ### sim/serial_pin_rate_ctrl_checker.sv
// Checker of port timing for the pin and rate block
`timescale 1ns/1ps
module serial_pin_rate_ctrl_checker (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Write
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic xferBusy, // Busy
   input wire logic sclk, // Clock out
   input wire logic masterMode, // Role
   input wire logic abortToIdle, // Abort
   input wire logic modeFault, // Fault
   input wire logic ssOut, // Select
   input wire logic select_output_en // Select oe
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held");
   ready_cause_a: assert property (
      pready |-> $past(psel && penable)) else $error("stray ready");
   error_ready_a: assert property (pslverr |-> pready)
      else $error("stray error");
   data_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("stray read data");
   idle_clock_a: assert property (!$past(xferBusy) |-> !sclk)
      else $error("clock while idle");
   slave_clock_a: assert property (
      !masterMode && !$past(masterMode) && !$past(masterMode, 2) |-> !sclk)
      else $error("clock as slave");
   slave_select_a: assert property (
      !masterMode && !$past(masterMode) |-> !select_output_en) else $error("ss driven");
   role_abort_a: assert property (
      $changed(masterMode) |-> ##[0:1] abortToIdle) else $error("no abort");
   select_idle_a: assert property (
      select_output_en && !$past(xferBusy) |-> ssOut) else $error("select low idle");
   fault_sticky_a: assert property (
      $past(modeFault) && !$past(pwrite) |-> modeFault) else $error("lost");
   cover property ($rose(sclk));
   cover property ($rose(modeFault));
   cover property (pslverr);
   cover property (abortToIdle && masterMode);
endmodule
bind serial_pin_rate_ctrl serial_pin_rate_ctrl_checker i_chk (.clk(clk),
   .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk(sclk),
   .xferBusy(xferBusy), .masterMode(masterMode), .ssOut(ssOut),
   .abortToIdle(abortToIdle), .modeFault(modeFault), .select_output_en(select_output_en));

// ### sim/serial_far_side.sv
// Far side peripheral model: data line and select line
`timescale 1ns/1ps
module serial_far_side (
   input wire logic clk, // Clock
   input wire logic selected, // Port selects us
   input wire logic faultReq, // Rival master pulls select low
   output logic farData, // Data toward the port
   output logic farSel // Select line level
);
   logic [7:0] lfsr = 8'ha5;
   // Line follows an LFSR bit, so a stale value passes as a match only when the bit repeats
   always_ff @(posedge clk) begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      farData <= lfsr[0] ^ !selected;
   end
   // Select line has a pull-up
   assign farSel = !faultReq;
endmodule

// ### sim/serial_port_pin_and_rate_control_test.sv
// Self-checking bench for the pin and rate block
`timescale 1ns/1ps
`define CHK(a, e) begin \
   total_checks++; \
   if ((a) !== (e)) begin \
      err_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); \
   end \
end
module serial_port_pin_and_rate_control_test;
   import serial_port_pkg::*;
   logic clk, rst, psel, penable, pwrite, waitMode, xferBusy, txBit, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, rxBit, sclk, sclkTick, masterMode, abortToIdle;
   logic modeFault, ssOut, select_output_en, mosiOut, mosiOe, misoOut, misoOe;
   logic farData, farSel, faultReq;
   int err_count, total_checks, seed, n, mdl[8];
   logic [2:0] lastIn;
   logic [19:0] pins[8] = '{20'h01002, 20'h03106, 20'h01102, 20'h01092,
      20'h01010, 20'h02101, 20'h00091, 20'h00010};
   logic [7:0] rates[6] = '{8'h00, 8'h01, 8'h10, 8'h23, 8'h52, 8'h77};
   wire logic ssIn = select_output_en ? ssOut : farSel;
   wire logic mosiIn = mosiOe ? mosiOut : farData;
   wire logic misoIn = misoOe ? misoOut : farData;
   serial_pin_rate_ctrl i_serial_pin_rate_ctrl (.clk(clk), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .waitMode(waitMode), .xferBusy(xferBusy), .txBit(txBit),
      .rxBit(rxBit), .sclk(sclk), .sclkTick(sclkTick), .ssIn(ssIn),
      .masterMode(masterMode), .abortToIdle(abortToIdle), .select_output_en(select_output_en),
      .modeFault(modeFault), .ssOut(ssOut), .mosiIn(mosiIn),
      .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn),
      .misoOut(misoOut), .misoOe(misoOe));
   serial_far_side i_serial_far_side (.clk(clk), .selected(!ssOut),
      .faultReq(faultReq), .farData(farData), .farSel(farSel));
   // Pin levels one clock back, matching the registered pin paths
   always @(posedge clk)
      lastIn <= {txBit, misoIn, mosiIn};
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task finish_test;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      logic [31:0] r;
      r = $random(seed);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {r[31:8], d};
      txBit <= r[0];
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      pwrite <= 0;
      if (k >= 20) begin
         err_count++;
         finish_test();
      end
   endtask
   task wr(input int i, input logic [7:0] v);
      apb(1, 8'(i << 2), v);
      mdl[i] = v & (i == 1 ? PC_WR_MASK : i == 2 ? RD_WR_MASK : PM_WR_MASK);
   endtask
   task rdchk(input int i);
      apb(0, 8'(i << 2), 8'h00);
      `CHK(rd, 32'(mdl[i]))
   endtask
   task ab(input int i, input logic [7:0] v, input logic e);
      int seen;
      xferBusy <= 1;
      wr(i, v);
      seen = 0;
      repeat (4) begin
         @(posedge clk);
         seen += abortToIdle;
      end
      `CHK(seen != 0, e)
      xferBusy <= 0;
      @(posedge clk);
   endtask
   task measure(input logic [7:0] r);
      logic s;
      wr(2, r);
      xferBusy <= 1;
      for (n = 0; sclk !== 1'b1 && n < 1100; n++)
         @(posedge clk);
      s = sclk;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (sclk === s && n < 1100);
      `CHK(n, (r[6:4] + 1) << r[2:0])
      `CHK(sclkTick, 1'b1)
      xferBusy <= 0;
      repeat (3) @(posedge clk);
   endtask
   initial begin
      {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
      {waitMode, xferBusy, txBit, faultReq} = 4'h0;
      {err_count, total_checks, seed} = {64'h0, 32'he20cd02d};
      repeat (20) @(posedge clk);
      rst <= 0;
      for (n = 1; n < 5; n++)
         rdchk(n);
      repeat (6) begin
         wr(1, 8'($random(seed)));
         wr(2, 8'($random(seed)));
         rdchk(1);
         rdchk(2);
      end
      apb(0, 8'h0c, 8'h00);
      `CHK({er, rd}, 33'h100000000)
      apb(0, 8'h05, 8'h00);
      `CHK({er, rd}, 33'h100000000)
      $display("register test done");
      foreach (pins[k]) begin
         wr(4, pins[k][19:12]);
         wr(1, pins[k][11:4]);
         repeat (3) @(posedge clk);
         `CHK({select_output_en, mosiOe, misoOe}, pins[k][2:0])
         `CHK(rxBit, lastIn[pins[k][12] ^ pins[k][4]])
         `CHK({mosiOut, misoOut}, pins[k][12] ? {lastIn[2], 1'b0} : {1'b0, lastIn[2]})
         `CHK(masterMode, pins[k][12])
      end
      wr(4, 8'h03);
      wr(1, 8'h10);
      xferBusy <= 1;
      repeat (4) @(posedge clk);
      `CHK({select_output_en, ssOut}, 2'b10)
      xferBusy <= 0;
      repeat (3) @(posedge clk);
      `CHK({select_output_en, ssOut}, 2'b11)
      $display("pin test done");
      wr(4, 8'h01);
      wr(1, 8'h00);
      waitMode <= 1;
      foreach (rates[k])
         measure(rates[k]);
      wr(1, 8'h02);
      wr(2, 8'h00);
      xferBusy <= 1;
      n = 0;
      repeat (30) begin
         @(posedge clk);
         n += sclk + sclkTick;
      end
      `CHK(n, 0)
      xferBusy <= 0;
      waitMode <= 0;
      $display("rate test done");
      wr(1, 8'h00);
      faultReq <= 1;
      repeat (3) @(posedge clk);
      `CHK(modeFault, 1'b0)
      wr(1, 8'h10);
      repeat (3) @(posedge clk);
      `CHK(modeFault, 1'b1)
      faultReq <= 0;
      wr(5, 8'h01);
      repeat (2) @(posedge clk);
      `CHK(modeFault, 1'b0)
      $display("fault test done");
      wr(4, 8'h00);
      wr(1, 8'h01);
      ab(4, 8'h01, 1'b1);
      ab(1, 8'h09, 1'b1);
      ab(2, 8'h13, 1'b1);
      ab(4, 8'h00, 1'b1);
      ab(2, 8'h00, 1'b0);
      $display("abort test done");
      finish_test();
   end
endmodule
